/* tb_top.sv */
// tb_top: self-checking bench for the fifo flag and transmit watchdog block
// assumes the host model drives the register port; reads are checked from a queue
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin miscompares++; $display("wrong value at %0t: got %h expected %h", $time, (a), (b)); end end

module tb_top
    import twd_pkg::*;
;
    localparam int TICK = 8;  // shortened 20 ms tick keeps the run brief

    // design stimulus and outputs
    logic                    sys_clk_i = 1'b0;
    logic                    rst_n_i   = 1'b0;
    logic                    soft_rst  = 1'b0;
    twd_req_s                req;
    logic [7:0]              rdata;
    logic [7:0][TWD_CNT_W-1:0] cnt;
    logic [7:0]              frame_done = '0;
    logic                    pend_en    = 1'b0;
    logic                    pend, int_req, wd_ev, armed;
    logic [7:0]              flags, stop;
    // bench bookkeeping
    int                      checked = 0, miscompares = 0, seed = 64, ev_cnt = 0, n, c;
    logic [7:0]              exp_q [$];
    logic [7:0]              exp_v, exp_f, mask_v;
    logic [7:0]              thr_v [8];
    logic [31:0]             r;
    logic                    rd_q = 1'b0;

    twd_flag_watchdog #(.TICK_CYCLES(TICK)) dut (
        .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .soft_reset_i(soft_rst), .req_i(req),
        .rdata_o(rdata), .tx_fifo_count_i(cnt), .frame_done_i(frame_done),
        .transmit_low_pending_enable_i(pend_en), .transmit_low_pending_o(pend),
        .int_req_o(int_req), .tx_fifo_low_flag_o(flags), .sched_stop_o(stop),
        .wd_event_o(wd_ev), .wd_armed_o(armed));

    twd_host_model host (.sys_clk_i(sys_clk_i), .req_o(req));

    // 25 MHz clock
    initial begin
        forever #20 sys_clk_i = ~sys_clk_i;
    end

    // note read strobes and watchdog events as the block takes them
    always @(posedge sys_clk_i) begin
        rd_q <= req.rd;
        if (wd_ev === 1'b1) ev_cnt <= ev_cnt + 1;
    end

    // read data stands from the read edge on: compare half a cycle later with the oldest note
    always @(negedge sys_clk_i) begin
        if (rd_q === 1'b1 && exp_q.size() != 0) begin
            exp_v = exp_q.pop_front();
            `CHK(rdata, exp_v)
        end
    end

    task automatic step(input int k);
        repeat (k) @(posedge sys_clk_i);
        #1;
    endtask

    // note the expected byte, then issue the read
    task automatic rd_exp(input logic [15:0] a, input logic [7:0] v);
        exp_q.push_back(v);
        host.access(1'b0, a, 8'h00);
    endtask

    task automatic conclude();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // hang guard
    initial begin
        repeat (100000) @(posedge sys_clk_i);
        miscompares++;
        conclude();
    end

    initial begin
        for (int i = 0; i < 8; i++) cnt[i] = 6'd20;  // above reset threshold
        step(12);
        `CHK(flags, TWD_RST_FLAGS)
        `CHK(armed, 1'b0)
        rst_n_i = 1'b1;
        rd_exp(TWD_ADDR_IRQ_EN, TWD_RST_IRQ_EN);
        rd_exp(TWD_ADDR_WD_MASK, TWD_RST_WD_MASK);
        rd_exp(TWD_ADDR_THR_FIRST, TWD_RST_THR);
        rd_exp(16'h8000, 8'h00);
        host.access(1'b1, TWD_ADDR_FLAGS, 8'hAA);  // read-only place, write ignored
        rd_exp(TWD_ADDR_FLAGS, 8'h00);
        // boundary passes at zero and all ones, then random thresholds and counts
        for (int p = 0; p < 5; p++) begin
            for (int i = 0; i < 8; i++) begin
                r = $random(seed);
                case (p)
                    0: thr_v[i] = {r[7:5], 5'h00};
                    1: thr_v[i] = {r[7:5], 5'h1F};
                    default: thr_v[i] = r[7:0];
                endcase
                c = (p == 0) ? i % 2 : (p == 1) ? 31 + i % 2 : int'(r[15:8]) % 33;
                host.access(1'b1, TWD_ADDR_THR_FIRST + 16'(i), thr_v[i]);
                rd_exp(TWD_ADDR_THR_FIRST + 16'(i), thr_v[i]);
                cnt[i] = 6'(c);
                exp_f[i] = (c <= int'(thr_v[i][4:0]));
            end
            step(2);
            `CHK(flags, exp_f)
            rd_exp(TWD_ADDR_FLAGS, exp_f);
        end
        // pending pulse only for enabled channels, pin gated by the enable input
        host.access(1'b1, TWD_ADDR_IRQ_EN, 8'h02);
        rd_exp(TWD_ADDR_IRQ_EN, 8'h02);
        for (int i = 0; i < 2; i++) host.access(1'b1, TWD_ADDR_THR_FIRST + 16'(i), 8'h00);
        cnt[0] = 6'd5;
        cnt[1] = 6'd5;
        step(2);
        cnt[0] = 6'd0;
        step(1);
        `CHK(pend, 1'b0)
        `CHK(flags[0], 1'b1)
        for (int e = 0; e < 2; e++) begin
            pend_en = e[0];
            cnt[1] = 6'd5;
            step(2);
            cnt[1] = 6'd0;
            step(1);
            `CHK(pend, 1'b1)
            `CHK(int_req, e[0])
            step(1);
            `CHK(pend, 1'b0)
        end
        // watchdog off: frame ends stop nothing
        frame_done = '1;
        step(1);
        frame_done = '0;
        step(1);
        `CHK(stop, 8'h00)
        r = $random(seed);
        mask_v = r[7:0] & 8'hDB;  // channels 2 and 5 always supervised
        host.arm(8'h03, mask_v);
        step(1);
        `CHK(armed, 1'b1)
        host.access(1'b1, TWD_ADDR_WD_MASK, TWD_MASK_ALL);  // disarm attempt
        rd_exp(TWD_ADDR_WD_MASK, mask_v);
        n = ev_cnt;
        repeat (4) begin
            host.refresh(8'h03);
            step(12);
        end
        `CHK(ev_cnt, n)
        // last refresh, then time the expiry: three ticks of TICK cycles
        host.refresh(8'h03);
        n = 0;
        while (wd_ev !== 1'b1 && n < 40) begin
            step(1);
            n++;
        end
        if (n >= 40) begin
            miscompares++;  // expiry never came; the report below still runs
        end else begin
            `CHK((n >= 2 * TICK + 1 && n <= 3 * TICK + 2), 1'b1)
            step(3);
            `CHK(stop, 8'h00)
            frame_done = '1;
            step(1);
            frame_done = '0;
            `CHK(stop, ~mask_v)
            step(5);
            `CHK(stop, ~mask_v)
            host.refresh(8'h05);
            step(1);
            `CHK(stop, 8'h00)
            `CHK(armed, 1'b1)
            soft_rst = 1'b1;
            step(1);
            soft_rst = 1'b0;
            `CHK(armed, 1'b0)
            rd_exp(TWD_ADDR_WD_MASK, TWD_RST_WD_MASK);
            // broken sequences: a wrong mask after all ones drops back to off,
            // and count then mask without the all-ones step never arms
            host.access(1'b1, TWD_ADDR_WD_MASK, TWD_MASK_ALL);
            host.access(1'b1, TWD_ADDR_WD_MASK, 8'h00);
            host.access(1'b1, TWD_ADDR_WD_COUNT, 8'h03);
            host.access(1'b1, TWD_ADDR_WD_MASK, 8'h00);
            step(1);
            `CHK(armed, 1'b0)
            rd_exp(TWD_ADDR_WD_MASK, 8'h00);
        end
        step(3);
        conclude();
    end
endmodule // tb_top

/* twd_flag_watchdog.sv */
// twd_flag_watchdog: fifo level flags, their interrupt routing and the transmit watchdog
// assumes fifo counts, frame ends and register strobes all come from logic on sys_clk_i
`timescale 1ns/1ps

module twd_flag_watchdog
    import twd_pkg::*;
#(
    parameter int TICK_CYCLES = TWD_TICK_CYCLES  // 20 ms at 25 MHz, shorten in simulation
) (
    // clock and reset
    input  wire logic                          sys_clk_i,
    input  wire logic                          rst_n_i,
    input  wire logic                          soft_reset_i,
    // register access from the host link
    input  wire twd_req_s                      req_i,
    output logic [7:0]                         rdata_o,
    // transmitter status
    input  wire logic [7:0][TWD_CNT_W-1:0]     tx_fifo_count_i,
    input  wire logic [7:0]                    frame_done_i,
    // interrupt handler side
    input  wire logic                          transmit_low_pending_enable_i,
    output logic                               transmit_low_pending_o,
    output logic                               int_req_o,
    // flags and watchdog outputs
    output logic [7:0]                         tx_fifo_low_flag_o,
    output logic [7:0]                         sched_stop_o,
    output logic                               wd_event_o,
    output logic                               wd_armed_o
);

    // register state
    logic [7:0][7:0]          thr_reg, thr_next;        // threshold per transmitter
    logic [7:0]               irq_en_reg, irq_en_next;  // per transmitter flag enable
    logic [7:0]               flag_reg, flag_next;      // fifo low flags
    logic                     pend_reg, pend_next;      // one-cycle pending set
    logic [7:0]               mask_reg, mask_next;      // watchdog channel mask
    logic [7:0]               cnt_reg, cnt_next;        // countdown value
    twd_wd_state_e            st_reg, st_next;          // arming sequence
    logic                     expired_reg, expired_next;
    logic                     event_reg, event_next;
    logic [7:0]               stop_pend_reg, stop_pend_next; // waiting for frame end
    logic [7:0]               stop_reg, stop_next;      // held stop level
    logic [TWD_PRE_W-1:0]     pre_reg, pre_next;        // 20 ms prescaler
    logic [7:0]               rdata_reg, rdata_next;
    logic [7:0]               flag_now;                 // live comparison result
    logic                     tick;
    logic                     wr_mask, wr_cnt;

    // per-transmitter comparison, a 6-bit count against a 5-bit threshold
    genvar gi;
    generate
        for (gi = 0; gi < TWD_NUM_TX; gi++) begin : g_cmp
            // zero flags only empty, all ones flags up to 31, i.e. not full
            assign flag_now[gi] = (tx_fifo_count_i[gi] <=
                {1'b0, thr_reg[gi][TWD_THR_MSB:0]}); // RQ1 RQ2 RQ3
        end
    endgenerate

    // tick is one cycle wide at prescaler wrap; software reset leaves the
    // prescaler alone, so a host cannot stretch an interval by resetting
    assign tick   = (pre_reg == TWD_PRE_W'(TICK_CYCLES - 1));
    assign wr_mask = req_i.wr && (req_i.addr == TWD_ADDR_WD_MASK);
    assign wr_cnt  = req_i.wr && (req_i.addr == TWD_ADDR_WD_COUNT);

    // next-state for all registers
    always_comb begin
        thr_next       = thr_reg;
        irq_en_next    = irq_en_reg;
        flag_next      = flag_now;                                       // RQ16
        // a new flag edge on an enabled channel requests the pending bit
        pend_next      = |(flag_now & ~flag_reg & irq_en_reg);           // RQ4
        mask_next      = mask_reg;
        cnt_next       = cnt_reg;
        st_next        = st_reg;
        expired_next   = expired_reg;
        event_next     = 1'b0;
        stop_pend_next = stop_pend_reg;
        stop_next      = stop_reg;
        // prescaler runs free so the first tick is at most 20 ms after arming
        pre_next       = tick ? '0 : pre_reg + TWD_PRE_W'(1);            // RQ17
        rdata_next     = rdata_reg;

        // plain register writes
        if (req_i.wr) begin
            if (req_i.addr == TWD_ADDR_IRQ_EN) begin
                irq_en_next = req_i.wdata;
            end
            if (req_i.addr >= TWD_ADDR_THR_FIRST && req_i.addr <= TWD_ADDR_THR_LAST) begin
                thr_next[req_i.addr[2:0]] = req_i.wdata;                 // RQ1
            end
        end

        // arming sequence; once armed, an all-ones mask write is dropped
        case (st_reg)
            // off: mask and count load freely, an all-ones mask starts arming
            TWD_WD_OFF: begin
                if (wr_mask) begin
                    mask_next = req_i.wdata;
                    if (req_i.wdata == TWD_MASK_ALL) begin
                        st_next = TWD_WD_MASKED;                          // RQ7
                    end
                end
                if (wr_cnt) begin
                    cnt_next = req_i.wdata;
                end
            end
            // masked: the count write is the second step of the sequence
            TWD_WD_MASKED: begin
                if (wr_mask) begin
                    mask_next = req_i.wdata;
                    if (req_i.wdata != TWD_MASK_ALL) begin
                        st_next = TWD_WD_OFF;                             // out of order
                    end
                end
                if (wr_cnt) begin
                    cnt_next = req_i.wdata;
                    st_next  = TWD_WD_LOADED;                             // RQ7
                end
            end
            // loaded: any mask other than all ones completes arming
            TWD_WD_LOADED: begin
                if (wr_cnt) begin
                    cnt_next = req_i.wdata;
                end
                if (wr_mask) begin
                    mask_next = req_i.wdata;
                    if (req_i.wdata != TWD_MASK_ALL) begin
                        st_next = TWD_WD_ARMED;                           // RQ7 RQ8
                    end
                end
            end
            TWD_WD_ARMED: begin
                // disarm attempts are ignored, other masks still apply
                if (wr_mask && req_i.wdata != TWD_MASK_ALL) begin
                    mask_next = req_i.wdata;                              // RQ14
                end
                if (wr_cnt) begin
                    // a write loads at once and wins over the tick
                    cnt_next = req_i.wdata;                               // RQ17 RQ15
                    if (req_i.wdata != 8'h00) begin
                        expired_next   = 1'b0;                            // RQ13
                        stop_pend_next = '0;
                        stop_next      = '0;
                    end
                end else if (tick && cnt_reg != 8'h00) begin
                    cnt_next = cnt_reg - 8'h01;                           // RQ9
                end
                // reaching zero fires once and marks supervised channels; a refresh
                // that lands on the zero cycle is too late, so the expiry wins over it
                if (cnt_reg == 8'h00 && !expired_reg) begin
                    expired_next   = 1'b1;
                    event_next     = 1'b1;                                // RQ11
                    stop_pend_next = ~mask_reg;                           // RQ12
                end
            end
            // an unused encoding falls back to off
            default: begin
                st_next = TWD_WD_OFF;
            end
        endcase

        // a marked channel stops only at the end of its current frame;
        // fifo messages never see this, the stop goes to the scheduler alone
        // a frame end in the same cycle as a resume write leaves the channel running
        for (int n = 0; n < TWD_NUM_TX; n++) begin
            if (stop_pend_reg[n] && frame_done_i[n] && stop_next[n] == stop_reg[n]
                && stop_pend_next[n]) begin
                stop_next[n]      = 1'b1;                                 // RQ11 RQ6 RQ18
                stop_pend_next[n] = 1'b0;
            end
        end

        // read data, unmapped addresses read zero
        // rdata is registered so it stands until the next read strobe
        if (req_i.rd) begin
            if (req_i.addr == TWD_ADDR_FLAGS) begin
                rdata_next = flag_reg;                                    // RQ16
            end else if (req_i.addr == TWD_ADDR_IRQ_EN) begin
                rdata_next = irq_en_reg;
            end else if (req_i.addr >= TWD_ADDR_THR_FIRST
                         && req_i.addr <= TWD_ADDR_THR_LAST) begin
                rdata_next = thr_reg[req_i.addr[2:0]];
            end else if (req_i.addr == TWD_ADDR_WD_MASK) begin
                rdata_next = mask_reg;
            end else if (req_i.addr == TWD_ADDR_WD_COUNT) begin
                rdata_next = cnt_reg;
            end else begin
                rdata_next = 8'h00;
            end
        end

        // software reset opcode returns everything except the read data register and the prescaler to its reset values
        // the prescaler is left running, it holds nothing the host can see
        if (soft_reset_i) begin
            thr_next       = {TWD_NUM_TX{TWD_RST_THR}};
            irq_en_next    = TWD_RST_IRQ_EN;
            flag_next      = TWD_RST_FLAGS;
            pend_next      = 1'b0;
            mask_next      = TWD_RST_WD_MASK;                             // RQ8
            cnt_next       = TWD_RST_WD_CNT;
            st_next        = TWD_WD_OFF;                                  // RQ14
            expired_next   = 1'b0;
            event_next     = 1'b0;
            stop_pend_next = '0;
            stop_next      = '0;
        end
    end

    // state registers, constants only under asynchronous reset
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            thr_reg       <= {TWD_NUM_TX{TWD_RST_THR}};
            irq_en_reg    <= TWD_RST_IRQ_EN;
            flag_reg      <= TWD_RST_FLAGS;                               // RQ16
            pend_reg      <= 1'b0;
            mask_reg      <= TWD_RST_WD_MASK;                             // RQ8
            cnt_reg       <= TWD_RST_WD_CNT;
            st_reg        <= TWD_WD_OFF;                                  // RQ6
            expired_reg   <= 1'b0;
            event_reg     <= 1'b0;
            stop_pend_reg <= '0;
            stop_reg      <= '0;
            pre_reg       <= '0;
            rdata_reg     <= 8'h00;
        end else begin
            thr_reg       <= thr_next;
            irq_en_reg    <= irq_en_next;
            flag_reg      <= flag_next;
            pend_reg      <= pend_next;
            mask_reg      <= mask_next;
            cnt_reg       <= cnt_next;
            st_reg        <= st_next;
            expired_reg   <= expired_next;
            event_reg     <= event_next;
            stop_pend_reg <= stop_pend_next;
            stop_reg      <= stop_next;
            pre_reg       <= pre_next;
            rdata_reg     <= rdata_next;
        end
    end

    // outputs
    // int_req_o is combinational so the enable input acts with no lag
    assign rdata_o                = rdata_reg;
    assign tx_fifo_low_flag_o     = flag_reg;
    assign transmit_low_pending_o = pend_reg;
    assign int_req_o              = pend_reg && transmit_low_pending_enable_i;  // RQ5
    assign sched_stop_o           = stop_reg;
    assign wd_event_o             = event_reg;
    assign wd_armed_o             = (st_reg == TWD_WD_ARMED);

    // checks
    empty_flag_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RQ2
        (tx_fifo_count_i[0] == '0 && !soft_reset_i) |=> tx_fifo_low_flag_o[0])
        else $error("empty fifo did not raise its flag");
    full_flag_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RQ3
        (tx_fifo_count_i[1] == 6'h20 && !soft_reset_i) |=> !tx_fifo_low_flag_o[1])
        else $error("full fifo left its flag set");
    pend_cause_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RQ4
        transmit_low_pending_o |-> |(tx_fifo_low_flag_o & ~$past(tx_fifo_low_flag_o)))
        else $error("pending set without a new flag");
    int_gate_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RQ5
        !transmit_low_pending_enable_i |-> !int_req_o)
        else $error("interrupt driven while disabled");
    never_disarm_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RQ14
        (wd_armed_o && !soft_reset_i) |=> wd_armed_o)
        else $error("armed watchdog was disarmed");
    count_step_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RQ9
        (wd_armed_o && tick && cnt_reg != 8'h00 && !wr_cnt && !soft_reset_i)
        |=> cnt_reg == $past(cnt_reg) - 8'h01)
        else $error("countdown did not step on tick");
    stop_mask_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RQ12
        $rose(wd_event_o) |-> ((stop_pend_reg & $past(mask_reg)) == 8'h00))
        else $error("masked-out channel marked for stop");
    stop_frame_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RQ11
        |(sched_stop_o & ~$past(sched_stop_o)) |-> |($past(frame_done_i)))
        else $error("stop raised before frame end");
    resume_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RQ13
        (wr_cnt && req_i.wdata != 8'h00 && wd_armed_o) |=> sched_stop_o == 8'h00)
        else $error("nonzero countdown write did not resume");
    off_reset_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RQ6
        soft_reset_i |=> !wd_armed_o && mask_reg == TWD_RST_WD_MASK)
        else $error("software reset left watchdog armed");

    // countdown load, event width and stop hold
    cnt_load_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RQ17
        (wr_cnt && !soft_reset_i) |=> cnt_reg == $past(req_i.wdata))
        else $error("countdown write did not load at once");
    event_pulse_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RQ11
        wd_event_o |=> !wd_event_o)
        else $error("watchdog event lasted more than one cycle");
    stop_hold_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RQ18
        (!wr_cnt && !soft_reset_i)
        |=> ((sched_stop_o & $past(sched_stop_o)) == $past(sched_stop_o)))
        else $error("stop level dropped without a write");

    // covers: arming, expiry, stop, interrupt request and resume
    armed_c: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i) $rose(wd_armed_o));
    expiry_c: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i) wd_event_o);
    stop_c: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i) |sched_stop_o);
    pend_c: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i) int_req_o);
    resume_c: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i) $fell(|sched_stop_o));

endmodule // twd_flag_watchdog

/* twd_host_model.sv */
// twd_host_model: behavioural host cpu that reaches the block registers over the strobe port
// assumes the bench calls its tasks from one process, one access at a time
`timescale 1ns/1ps

module twd_host_model
    import twd_pkg::*;
(
    // clock
    input  wire logic sys_clk_i,
    // register requests towards the block
    output twd_req_s  req_o
);
    initial req_o = '0;  // idle from time zero

    // one access: raise just after an edge, hold through the taking edge, then release
    task automatic access(input logic wr, input logic [15:0] addr, input logic [7:0] data);
        @(posedge sys_clk_i);
        #1;
        req_o = '{wr: wr, rd: !wr, addr: addr, wdata: data};
        @(posedge sys_clk_i);
        #1;
        // released bus shows inverted values so stale data is never taken for live
        req_o = '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: ~data};
    endtask

    // arming must be strictly ordered: all-ones mask, count, then a real mask
    task automatic arm(input logic [7:0] cnt, input logic [7:0] mask);
        access(1'b1, TWD_ADDR_WD_MASK, TWD_MASK_ALL);
        access(1'b1, TWD_ADDR_WD_COUNT, cnt);
        access(1'b1, TWD_ADDR_WD_MASK, mask);
    endtask

    // refresh before the count runs out keeps schedulers alive
    task automatic refresh(input logic [7:0] cnt);
        access(1'b1, TWD_ADDR_WD_COUNT, cnt);
    endtask
endmodule // twd_host_model

/* twd_pkg.sv */
// twd_pkg: constants, types and register map for the transmit fifo flag and watchdog block
// assumes a same-clock register port from the host serial link decoder and 6-bit fifo counts
// Function
// RQ1 - per-transmitter 5-bit threshold, flag when count <= threshold
// RQ2 - threshold zero flags only an empty fifo
// RQ3 - threshold all ones flags while not full
// RQ4 - enabled rising flag sets transmit pending bit
// RQ5 - interrupt pin only when pending enable set
// RQ6 - watchdog off after reset, stops only scheduler
// RQ7 - host arms: mask ones, count, then mask
// RQ8 - mask bit zero supervises channel, resets ones
// RQ9 - armed countdown decrements every 20 ms
// RQ10 - host refreshes countdown before it reaches zero
// RQ11 - expiry raises event, stops after current frame
// RQ12 - expiry stops only channels with mask zero
// RQ13 - nonzero countdown write resumes stopped channels
// RQ14 - armed watchdog cannot be disarmed except reset
// RQ15 - countdown lsb is 20 ms, 0xFF is 5.1 s
// RQ16 - flags readable as one register, reset ones
// RQ17 - free-running prescaler tick, writes load immediately
// RQ18 - stop level held until nonzero write or reset
package twd_pkg;

    // register addresses as printed
    localparam logic [15:0] TWD_ADDR_FLAGS     = 16'h800F;
    localparam logic [15:0] TWD_ADDR_IRQ_EN    = 16'h804F;
    localparam logic [15:0] TWD_ADDR_THR_FIRST = 16'h8060;
    localparam logic [15:0] TWD_ADDR_THR_LAST  = 16'h8067;
    localparam logic [15:0] TWD_ADDR_WD_MASK   = 16'h807E;
    localparam logic [15:0] TWD_ADDR_WD_COUNT  = 16'h807F;

    // reset values
    localparam logic [7:0] TWD_RST_FLAGS   = 8'hFF;
    localparam logic [7:0] TWD_RST_IRQ_EN  = 8'h00;
    localparam logic [7:0] TWD_RST_THR     = 8'h00;
    localparam logic [7:0] TWD_RST_WD_MASK = 8'hFF;
    localparam logic [7:0] TWD_RST_WD_CNT  = 8'h00;
    localparam logic [7:0] TWD_MASK_ALL    = 8'hFF;

    // field layout and sizes
    localparam int TWD_NUM_TX    = 8;
    localparam int TWD_THR_MSB   = 4;
    localparam int TWD_CNT_W     = 6;
    localparam int TWD_PRE_W     = 20;

    // timing: watchdog lsb in milliseconds and the clock rate
    localparam int TWD_TICK_MS    = 20;
    localparam int TWD_CLK_HZ     = 25_000_000;
    localparam int TWD_TICK_CYCLES = TWD_CLK_HZ / 1000 * TWD_TICK_MS;

    // arming sequence states
    typedef enum logic [1:0] {
        TWD_WD_OFF,
        TWD_WD_MASKED,
        TWD_WD_LOADED,
        TWD_WD_ARMED
    } twd_wd_state_e;

    // one register access from the host link decoder
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } twd_req_s;

endpackage
